// ### rtl/twm_regs.svh
// Operation
// - master only, no arbitration, single master bus
// - single and multi byte reads and writes
// - bit rate selectable, 100 or 400 kbit/s
// - slave memory addressed with 11 or 16 bits
// - clock pin output only, open drain
// - data pin bidirectional, open drain
// - master starts transfers and makes the clock
// - bytes sent serially, most significant bit first
// - start condition first, stop condition last
// - data changes only while clock low
// - start is data falling while clock high
// - stop is data rising while clock high
// - receiver acknowledges low on ninth clock
// - transmitter releases data during acknowledge clock
// - master withholds acknowledge after last read byte
// - pin pull-ups enabled after every reset
// - parts under 4K bytes use 11 bits
// - parts 4K bytes or more use 16 bits
// - select strap lsb at 1 marks larger part
// - device address register, memory address as data
// - stop bit ends transfer after current byte
// - tx empty resets 1, clears on write, sets on load
// - rx full resets 0, sets on load, clears on read
// - bus error set on no answer, write 1 clears
`ifndef TWM_REGS_SVH
`define TWM_REGS_SVH

`define TWM_OFS_CSR 8'h00
`define TWM_OFS_ADR 8'h04
`define TWM_OFS_TXD 8'h08
`define TWM_OFS_RXD 8'h0C

`define TWM_CSR_STOP 0
`define TWM_CSR_TXE 2
`define TWM_CSR_FAST 3
`define TWM_CSR_ERR 5
`define TWM_CSR_RXF 7

`define TWM_RST_STOP 1'b0
`define TWM_RST_TXE 1'b1
`define TWM_RST_FAST 1'b0
`define TWM_RST_ERR 1'b0
`define TWM_RST_RXF 1'b0
`define TWM_RST_BYTE 8'h00

`define TWM_CLK_NS 20
`define TWM_BIT_SLOW_NS 10000
`define TWM_BIT_FAST_NS 2500
`define TWM_Q_SLOW ((`TWM_BIT_SLOW_NS / 4 + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`define TWM_Q_FAST ((`TWM_BIT_FAST_NS / 4 + `TWM_CLK_NS - 1) / `TWM_CLK_NS)

`endif

// ### rtl/twm_pkg.sv
package twm_pkg;

  typedef enum logic [2:0]
  {
    TWM_IDLE = 3'h0,
    TWM_START = 3'h1,
    TWM_BIT = 3'h3,
    TWM_HOLD = 3'h2,
    TWM_STOP = 3'h6
  } twm_state_t;

  typedef struct packed
  {
    logic rx_full_flag;
    logic err;
    logic fast;
    logic tx_empty_flag;
    logic stop;
  } twm_csr_t;

endpackage

// ### rtl/twm_bit_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "twm_regs.svh"

module twm_bit_timer
  import twm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fast,
  output logic tick
);

  localparam logic [7:0] QS = 8'(`TWM_Q_SLOW);
  localparam logic [7:0] QF = 8'(`TWM_Q_FAST);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_tick;

  // quarter-bit strobe; rounded up so the bus never runs above the rate
  always_comb
  begin
    next_tick = 1'b0;
    next_cnt = cnt + 8'h01;
    if (cnt >= (fast ? QF : QS) - 8'h01)
    begin
      next_cnt = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ### rtl/twm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "twm_regs.svh"

module twm_top
  import twm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic scl_pullup_en,
  output logic sda_pullup_en
);

  // bus slave

  logic req;
  logic wr_acc;
  logic rd_acc;
  logic next_ack;
  logic [31:0] next_dat;
  twm_csr_t csr;
  logic [7:0] adr;
  logic [7:0] txd;
  logic [7:0] rxd;

  assign req = wb_cyc_i & wb_stb_i;
  // writes and read side effects happen on the edge that sees ack
  assign wr_acc = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd_acc = req & wb_ack_o & ~wb_we_i;

  function automatic logic [7:0] csr_byte(input twm_csr_t c);
    logic [7:0] b;
    b = 8'h00;
    b[`TWM_CSR_STOP] = c.stop;
    b[`TWM_CSR_TXE] = c.tx_empty_flag;
    b[`TWM_CSR_FAST] = c.fast;
    b[`TWM_CSR_ERR] = c.err;
    b[`TWM_CSR_RXF] = c.rx_full_flag;
    return b;
  endfunction

  always_comb
  begin
    next_ack = req & ~wb_ack_o;
    next_dat = wb_dat_o;
    if (req & ~wb_ack_o)
    begin
      unique case (wb_adr_i)
        `TWM_OFS_CSR: next_dat = {24'h000000, csr_byte(csr)};
        `TWM_OFS_ADR: next_dat = {24'h000000, adr};
        `TWM_OFS_TXD: next_dat = {24'h000000, txd};
        `TWM_OFS_RXD: next_dat = {24'h000000, rxd};
        default: next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // pins

  logic sda_meta;
  logic sda_s;
  logic tick;

  // open drain: only ever drive zero, the enables do the signalling
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      scl_pullup_en <= 1'b1;
      sda_pullup_en <= 1'b1;
    end
    else
    begin
      sda_meta <= sda_i;
      sda_s <= sda_meta;
      scl_pullup_en <= 1'b1;
      sda_pullup_en <= 1'b1;
    end
  end

  twm_bit_timer u_timer
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fast(csr.fast),
    .tick(tick)
  );

  // controller; no arbitration, the bus must have no other master

  twm_state_t st;
  twm_state_t next_st;
  logic [1:0] qc;
  logic [1:0] next_qc;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic is_addr;
  logic next_is_addr;
  logic tx_mode;
  logic next_tx_mode;
  logic nack;
  logic next_nack;
  logic go;
  logic next_go;
  logic next_scl_oe_n;
  logic next_sda_oe_n;
  twm_csr_t next_csr;
  logic [7:0] next_adr;
  logic [7:0] next_txd;
  logic [7:0] next_rxd;

  always_comb
  begin
    next_st = st;
    next_qc = tick ? qc + 2'h1 : qc;
    next_bitn = bitn;
    next_sh = sh;
    next_is_addr = is_addr;
    next_tx_mode = tx_mode;
    next_nack = nack;
    next_go = go;
    next_scl_oe_n = scl_oe_n;
    next_sda_oe_n = sda_oe_n;
    next_csr = csr;
    next_adr = adr;
    next_txd = txd;
    next_rxd = rxd;

    // software side first, so hardware sets below win
    if (wr_acc)
    begin
      unique case (wb_adr_i)
        `TWM_OFS_CSR:
        begin
          next_csr.stop = wb_dat_i[`TWM_CSR_STOP];
          next_csr.fast = wb_dat_i[`TWM_CSR_FAST];
          if (wb_dat_i[`TWM_CSR_ERR])
            next_csr.err = 1'b0;
        end
        `TWM_OFS_ADR:
        begin
          next_adr = wb_dat_i[7:0];
          next_go = 1'b1;
        end
        `TWM_OFS_TXD:
        begin
          next_txd = wb_dat_i[7:0];
          next_csr.tx_empty_flag = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    if (rd_acc && wb_adr_i == `TWM_OFS_RXD)
      next_csr.rx_full_flag = 1'b0;

    if (st == TWM_IDLE || st == TWM_HOLD)
      next_qc = 2'h0;

    if (tick)
    begin
      unique case (st)
        TWM_IDLE:
        begin
          next_scl_oe_n = 1'b1;
          next_sda_oe_n = 1'b1;
          // a write waits for its first data byte, a read starts at once
          if (go && (adr[0] || !csr.tx_empty_flag))
            next_st = TWM_START;
        end
        TWM_START:
        begin
          unique case (qc)
            2'h0:
            begin
              next_scl_oe_n = 1'b0;
              next_sda_oe_n = 1'b1;
            end
            2'h1: next_scl_oe_n = 1'b1;
            2'h2: next_sda_oe_n = 1'b0;
            2'h3:
            begin
              next_scl_oe_n = 1'b0;
              next_st = TWM_BIT;
              next_sh = adr;
              next_is_addr = 1'b1;
              next_tx_mode = 1'b1;
              next_bitn = 4'h0;
              next_go = 1'b0;
            end
          endcase
        end
        TWM_BIT:
        begin
          unique case (qc)
            2'h0:
            begin
              // data moves only here, with the clock low
              next_scl_oe_n = 1'b0;
              if (bitn == 4'h8)
                next_sda_oe_n = tx_mode | csr.stop;
              else
                next_sda_oe_n = tx_mode ? sh[7] : 1'b1;
            end
            2'h1: next_scl_oe_n = 1'b1;
            2'h2:
            begin
              if (bitn == 4'h8)
                next_nack = sda_s;
              else if (!tx_mode)
                next_sh = {sh[6:0], sda_s};
            end
            2'h3:
            begin
              next_scl_oe_n = 1'b0;
              if (bitn != 4'h8)
              begin
                if (tx_mode)
                  next_sh = {sh[6:0], 1'b0};
                if (!tx_mode && bitn == 4'h7)
                begin
                  next_rxd = sh;
                  next_csr.rx_full_flag = 1'b1;
                end
                next_bitn = bitn + 4'h1;
              end
              else
              begin
                next_bitn = 4'h0;
                if (tx_mode && nack)
                begin
                  next_csr.err = 1'b1;
                  next_st = TWM_STOP;
                end
                else if (is_addr && adr[0])
                begin
                  next_is_addr = 1'b0;
                  next_tx_mode = 1'b0;
                end
                else if (!is_addr && csr.stop)
                  next_st = TWM_STOP;
                else
                begin
                  next_is_addr = 1'b0;
                  next_st = TWM_HOLD;
                end
              end
            end
          endcase
        end
        TWM_HOLD:
        begin
          // clock held low while software catches up
          if (go)
            next_st = TWM_START;
          else if (!tx_mode && !csr.rx_full_flag)
            next_st = TWM_BIT;
          else if (tx_mode && !csr.tx_empty_flag)
          begin
            next_sh = txd;
            next_csr.tx_empty_flag = 1'b1;
            next_st = TWM_BIT;
          end
        end
        TWM_STOP:
        begin
          unique case (qc)
            2'h0:
            begin
              next_scl_oe_n = 1'b0;
              next_sda_oe_n = 1'b0;
            end
            2'h1: next_scl_oe_n = 1'b1;
            2'h2: next_sda_oe_n = 1'b1;
            2'h3: next_st = TWM_IDLE;
          endcase
        end
        default: next_st = TWM_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= TWM_IDLE;
      qc <= 2'h0;
      bitn <= 4'h0;
      sh <= `TWM_RST_BYTE;
      is_addr <= 1'b0;
      tx_mode <= 1'b0;
      nack <= 1'b0;
      go <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      csr.stop <= `TWM_RST_STOP;
      csr.tx_empty_flag <= `TWM_RST_TXE;
      csr.fast <= `TWM_RST_FAST;
      csr.err <= `TWM_RST_ERR;
      csr.rx_full_flag <= `TWM_RST_RXF;
      adr <= `TWM_RST_BYTE;
      txd <= `TWM_RST_BYTE;
      rxd <= `TWM_RST_BYTE;
    end
    else
    begin
      st <= next_st;
      qc <= next_qc;
      bitn <= next_bitn;
      sh <= next_sh;
      is_addr <= next_is_addr;
      tx_mode <= next_tx_mode;
      nack <= next_nack;
      go <= next_go;
      scl_oe_n <= next_scl_oe_n;
      sda_oe_n <= next_sda_oe_n;
      csr <= next_csr;
      adr <= next_adr;
      txd <= next_txd;
      rxd <= next_rxd;
    end
  end

endmodule
`default_nettype wire

// ### dv/twm_props.sv
`timescale 1ns/100ps
`default_nettype none
module twm_props
  import twm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic scl_pullup_en,
  input wire logic sda_pullup_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  sequence s_stop;
    $rose(sda_oe_n) && scl_oe_n;
  endsequence
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_pullups_on: assert property (scl_pullup_en && sda_pullup_en)
    else $error("pull-up off");
  chk_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  chk_start_form: assert property (s_start |=> (scl_oe_n && !sda_oe_n)[*8])
    else $error("bad start");
  chk_stop_form: assert property (s_stop |=> (scl_oe_n && sda_oe_n)[*8])
    else $error("bad stop");
  chk_high_stable: assert property ($rose(scl_oe_n) |-> $stable(sda_oe_n)[*8])
    else $error("data moved, clock high");
  chk_low_width: assert property ($fell(scl_oe_n) |-> !scl_oe_n[*8])
    else $error("clock low too short");
endmodule
bind twm_top twm_props chk_u (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .scl_o,
  .scl_oe_n, .sda_o, .sda_oe_n, .scl_pullup_en, .sda_pullup_en);
`default_nettype wire

// ### dv/twm_eeprom.sv
`timescale 1ns/100ps
`default_nettype none
module twm_eeprom
  import twm_pkg::*;
#(
  parameter logic [6:0] DEV = 7'h50
)
(
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr;
  logic act = 0, first, rd, ok, ap, mack;
  int n;
  initial pull = 0;
  always @(negedge sda)
    if (scl)
    begin
      act = 1;
      first = 1;
      n = 0;
    end
  always @(posedge sda)
    if (scl)
      act = 0;
  always @(posedge scl)
    if (act)
    begin
      if (n < 8)
        sh = {sh[6:0], sda};
      else
        mack = !sda;
      n++;
    end
  // drive only after clock falls, so data never moves with clock high
  always @(negedge scl)
    if (act)
    begin
      pull = 0;
      if (n == 8 && (first || !rd))
      begin
        if (first)
        begin
          rd = sh[0];
          ok = sh[7:1] == DEV;
          ap = !sh[0];
        end
        else if (ap)
        begin
          ptr = sh;
          ap = 0;
        end
        else
        begin
          mem[ptr] = sh;
          ptr++;
        end
        pull = ok;
      end
      if (n == 9)
      begin
        n = 0;
        ok = ok && (first || mack);
        first = 0;
        tx = mem[ptr];
        ptr = ptr + {7'h0, rd & ok};
      end
      if (n < 8 && rd && !first && ok)
        pull = !tx[7 - n];
    end
endmodule
`default_nettype wire

// ### dv/two_wire_eeprom_master_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "twm_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module two_wire_eeprom_master_test
  import twm_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, fs = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o, scl_o, scl_oe_n, sda_o, sda_oe_n, pull, sda_w;
  int err_count = 0, total_checks = 0, cyc_n = 0;
  logic [15:0] q[$];
  logic [15:0] note;
  logic [7:0] rd, a, d0, d1;
  always #10 sys_clk = ~sys_clk;
  // released lines float high through the pull-ups
  assign sda_w = sda_oe_n & !pull;
  twm_top dut_u (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .scl_o, .scl_oe_n, .sda_i(sda_w), .sda_o, .sda_oe_n,
    .scl_pullup_en(), .sda_pullup_en());
  twm_eeprom ee_u (.scl(scl_oe_n), .sda(sda_w), .pull);
  task tally_and_finish;
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] ad, dt, m = 0, e = 0);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= {24'h0, dt};
    if (!we)
      q.push_back({m, e});
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge sys_clk);
  endtask
  task automatic poll(input logic [7:0] m, v);
    do wb(0, `TWM_OFS_CSR, 0); while ((rd & m) !== v);
  endtask
  task automatic idle;
    while (!ee_u.act) @(posedge sys_clk);
    while (ee_u.act) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk)
  begin
    if (wb_ack_o === 1'b1 && !wb_we_i)
    begin
      note = q.pop_front();
      if (note[15:8] != 0)
        `CHK("read", note[7:0], wb_dat_o[7:0] & note[15:8])
    end
    cyc_n++;
    // ceiling well above the slow-rate transfers
    if (cyc_n == 90000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(32'hF7C5EC91));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    wb(0, `TWM_OFS_CSR, 0, 8'hFF, 8'h04);
    wb(1, 8'h10, 8'hFF);
    wb(0, 8'h10, 0, 8'hFF, 0);
    wb(0, `TWM_OFS_RXD, 0, 8'hFF, 0);
    repeat (2)
    begin
      a = 8'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      wb(1, `TWM_OFS_CSR, {4'h0, fs, 3'h0});
      wb(1, `TWM_OFS_ADR, {7'h50, 1'b0});
      wb(1, `TWM_OFS_TXD, a);
      wb(0, `TWM_OFS_CSR, 0, 8'h04, 0);
      poll(8'h04, 8'h04);
      wb(1, `TWM_OFS_TXD, d0);
      poll(8'h04, 8'h04);
      wb(1, `TWM_OFS_TXD, d1);
      poll(8'h04, 8'h04);
      wb(1, `TWM_OFS_CSR, {4'h0, fs, 3'h1});
      idle();
      `CHK("mem lo", d0, ee_u.mem[a])
      `CHK("mem hi", d1, ee_u.mem[a + 8'h01])
      wb(1, `TWM_OFS_CSR, {4'h0, fs, 3'h0});
      wb(1, `TWM_OFS_ADR, {7'h50, 1'b0});
      wb(1, `TWM_OFS_TXD, a);
      poll(8'h04, 8'h04);
      wb(1, `TWM_OFS_ADR, {7'h50, 1'b1});
      poll(8'h80, 8'h80);
      // let the first byte's acknowledge bit pass before asking for stop
      repeat (4 * `TWM_Q_SLOW + 20) @(posedge sys_clk);
      wb(1, `TWM_OFS_CSR, {4'h0, fs, 3'h1});
      wb(0, `TWM_OFS_RXD, 0, 8'hFF, d0);
      poll(8'h80, 8'h80);
      wb(0, `TWM_OFS_RXD, 0, 8'hFF, d1);
      idle();
      wb(0, `TWM_OFS_CSR, 0, 8'h80, 0);
      `CHK("last ack", 1'b0, ee_u.mack)
      fs = 1;
    end
    wb(1, `TWM_OFS_ADR, {7'h51, 1'b1});
    idle();
    wb(0, `TWM_OFS_CSR, 0, 8'h20, 8'h20);
    wb(1, `TWM_OFS_CSR, 0);
    wb(0, `TWM_OFS_CSR, 0, 8'h20, 8'h20);
    wb(1, `TWM_OFS_CSR, 8'h20);
    wb(0, `TWM_OFS_CSR, 0, 8'h20, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
